// >>> hdl/ddsc_pkg.sv
// constants and carrier types for the dual converter command decoder
`default_nettype none
package ddsc_pkg;
	localparam int WORD_BITS   = 16;
	localparam int DATA_BITS   = 12;
	localparam int SEL_UP_POS  = 15;
	localparam int SPEED_POS   = 14;
	localparam int POWER_POS   = 13;
	localparam int SEL_LO_POS  = 12;
	localparam int VREF_HI_POS = 1;
	localparam int VREF_LO_POS = 0;
	localparam int FIFO_DEPTH  = 8;
	localparam logic [11:0] CODE_RESET = 12'h000;
	localparam logic [1:0]  VREF_RESET = 2'h0;
	localparam logic [4:0]  BITS_FULL  = 5'h10;

	typedef enum logic [1:0] {
		DDSC_VREF_EXT,
		DDSC_VREF_1V024,
		DDSC_VREF_2V048
	} ddsc_vref_t;

	// one captured frame on its way to the decoder
	typedef struct packed {
		logic        select_upper;
		logic        settle_speed;
		logic        power_down_bit;
		logic        select_lower;
		logic [11:0] data;
	} ddsc_word_t;

	typedef struct packed {
		logic [11:0] first_channel_code;
		logic [11:0] second_channel_code;
		logic [11:0] holding_buffer;
		logic [1:0]  reference_control;
		logic        settle_speed;
		logic        power_down;
	} ddsc_latch_t;

	// two-bit reference field to reference source
	function automatic ddsc_vref_t ddsc_vref_decode(input logic [1:0] f);
		case (f)
			2'h1:    ddsc_vref_decode = DDSC_VREF_1V024;
			2'h2:    ddsc_vref_decode = DDSC_VREF_2V048;
			default: ddsc_vref_decode = DDSC_VREF_EXT;
		endcase
	endfunction
endpackage
`default_nettype wire

// >>> hdl/ddsc_fifo.sv
// small flip-flop FIFO between the frame capture and the decoder
`timescale 1ns/1ps
`default_nettype none
module ddsc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output var  logic             in_ready,
	output var  logic [WIDTH-1:0] out_data,
	output var  logic             out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} ddsc_fifo_st_t;
	ddsc_fifo_st_t st;
	ddsc_fifo_st_t next_st;
	logic push;
	logic pop;

	always_comb begin
		next_st = st;
		push = in_valid && (st.cnt != (AW+1)'(DEPTH));
		pop = out_ready && (st.cnt != '0);
		if (push) begin
			next_st.mem[st.wp] = in_data;
			next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + AW'(1);
		end
		if (pop)
			next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + AW'(1);
		if (push && !pop)
			next_st.cnt = st.cnt + (AW+1)'(1);
		else if (pop && !push)
			next_st.cnt = st.cnt - (AW+1)'(1);
	end

	always_ff @(posedge clk) begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign in_ready = st.cnt != (AW+1)'(DEPTH);
	assign out_valid = st.cnt != '0;
	assign out_data = st.mem[st.rp];
endmodule
`default_nettype wire

// >>> hdl/ddsc_top.sv
// serial command decoder for a dual 12-bit voltage-output converter
// Overview of operation
// - after select falls, bits enter MSB first on each falling serial clock
// - sixteen bits or early select rise move the word to its target
// - bit 15 and 12 select target, 14 speed, 13 power, then data
// - power-on reset clears every latch to zero
// - selects 00 load second channel and holding buffer
// - selects 01 load holding buffer only, channel outputs unchanged
// - selects 10 load first channel, copy buffer into second channel
// - selects 11 send the word to the control latch
// - channel and buffer writes take all twelve data bits unsigned
// - control writes use only data bits 1 and 0
// - reference 00/11 external, 01 internal 1.024 V, 10 internal 2.048 V
// - first channel changes two clocks after the final bit's capture, through the fifo
// - combined update changes both channels together
// - control latch holds across later channel and buffer writes
// - any word with bit 13 set enters power-down
// - every word carries speed, control words included
`timescale 1ns/1ps
`default_nettype none
module ddsc_top
	import ddsc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	output var  logic [11:0] first_channel_code,
	output var  logic [11:0] second_channel_code,
	output var  logic [1:0]  vref_source,
	output var  logic        settle_speed,
	output var  logic        power_down,
	output var  logic        overrun
);
	typedef struct packed {
		logic [1:0]   sclk_sync;
		logic [1:0]   cs_sync;
		logic [1:0]   din_sync;
		logic         sclk_prev;
		logic         cs_prev;
		logic [15:0]  shift;
		logic [4:0]   nbits;
		logic         done;
		logic [15:0]  word;
		logic         word_valid;
		ddsc_latch_t  lat;
		logic [1:0]   vref_out;
		logic         overrun;
	} ddsc_st_t;

	ddsc_st_t    st;
	ddsc_st_t    next_st;
	ddsc_word_t  fifo_word;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [15:0] fifo_out_data;
	logic        sclk_fall;
	logic        cs_rise;
	logic        cs_low;

	ddsc_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst      (rst),
		.in_data  (st.word),
		.in_valid (st.word_valid),
		.in_ready (fifo_in_ready),
		.out_data (fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(1'b1)
	);

	assign fifo_word = ddsc_word_t'(fifo_out_data);

	always_comb begin
		next_st = st;
		// two stages on every pin before any logic reads it
		next_st.sclk_sync = {st.sclk_sync[0], sclk};
		next_st.cs_sync = {st.cs_sync[0], cs_n};
		next_st.din_sync = {st.din_sync[0], din};
		next_st.sclk_prev = st.sclk_sync[1];
		next_st.cs_prev = st.cs_sync[1];
		sclk_fall = st.sclk_prev && !st.sclk_sync[1];
		cs_rise = !st.cs_prev && st.cs_sync[1];
		cs_low = !st.cs_sync[1];
		next_st.word_valid = 1'b0;

		if (cs_low && sclk_fall && !st.done) begin
			next_st.shift = {st.shift[14:0], st.din_sync[1]};
			next_st.nbits = st.nbits + 5'h01;
			if (st.nbits == BITS_FULL - 5'h01) begin
				next_st.word = {st.shift[14:0], st.din_sync[1]};
				next_st.word_valid = 1'b1;
				next_st.done = 1'b1;
			end
		end
		// early rise of select moves what was shifted
		if (cs_rise) begin
			if (!st.done && st.nbits != 5'h00) begin
				next_st.word = st.shift;
				next_st.word_valid = 1'b1;
			end
			next_st.nbits = 5'h00;
			next_st.done = 1'b0;
			next_st.shift = 16'h0000;
		end
		// fifo never fills with an always-ready drain; flag it if it did
		if (next_st.word_valid && !fifo_in_ready)
			next_st.overrun = 1'b1;

		if (fifo_out_valid) begin
			next_st.lat.settle_speed = fifo_word.settle_speed;
			next_st.lat.power_down = fifo_word.power_down_bit;
			// target from bits 15 and 12
			case ({fifo_word.select_upper, fifo_word.select_lower})
				2'b00: begin
					next_st.lat.second_channel_code = fifo_word.data;
					next_st.lat.holding_buffer = fifo_word.data;
				end
				2'b01: begin
					next_st.lat.holding_buffer = fifo_word.data;
				end
				2'b10: begin
					next_st.lat.first_channel_code = fifo_word.data;
					next_st.lat.second_channel_code = st.lat.holding_buffer;
				end
				// only bits 1 and 0 kept
				2'b11: begin
					next_st.lat.reference_control =
						fifo_word.data[VREF_HI_POS:VREF_LO_POS];
				end
				default: begin
				end
			endcase
		end
		next_st.vref_out = 2'(ddsc_vref_decode(next_st.lat.reference_control));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
			st.sclk_sync <= 2'h0;
			st.cs_sync <= 2'h3;
			st.cs_prev <= 1'b1;
			st.lat.first_channel_code <= CODE_RESET;
			st.lat.second_channel_code <= CODE_RESET;
			st.lat.holding_buffer <= CODE_RESET;
			st.lat.reference_control <= VREF_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign first_channel_code = st.lat.first_channel_code;
	assign second_channel_code = st.lat.second_channel_code;
	assign vref_source = st.vref_out;
	assign settle_speed = st.lat.settle_speed;
	assign power_down = st.lat.power_down;
	assign overrun = st.overrun;
endmodule
`default_nettype wire

// >>> verification/ddsc_monitor.sv
// port assertions for the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module ddsc_monitor (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        sclk,
	input wire logic        cs_n,
	input wire logic [11:0] first_channel_code,
	input wire logic [11:0] second_channel_code,
	input wire logic [1:0]  vref_source,
	input wire logic        settle_speed,
	input wire logic        power_down,
	input wire logic        overrun
);
	logic [27:0] o;
	logic [4:0]  age;
	logic        sclk_q, cs_q;
	assign o = {first_channel_code, second_channel_code, vref_source,
		settle_speed, power_down};
	// age since frame event; saturates so idle time never wraps
	always_ff @(posedge clk) begin
		{sclk_q, cs_q} <= {sclk, cs_n};
		if (rst || (sclk_q && !sclk && !cs_n) || (!cs_q && cs_n))
			age <= 5'h00;
		else if (age != 5'h1F)
			age <= age + 5'h01;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_idle; cs_n [*8] ##1 cs_n [*4]; endsequence
	AST_RESET: assert property ($fell(rst) |-> o == 28'h0)
		else $error("no clear");
	AST_QUIET: assert property (s_idle |-> $stable(o))
		else $error("idle change");
	AST_LATE: assert property ($changed(o) |->
		age inside {[5'h03:5'h0A]}) else $error("late");
	AST_PAIR: assert property ($changed(first_channel_code) |=>
		$stable(second_channel_code)) else $error("split");
	AST_PAIR_B: assert property ($changed(second_channel_code) |=>
		$stable(first_channel_code)) else $error("split late");
	AST_CHAN: assert property ($changed(o[27:4]) |->
		$stable(vref_source)) else $error("ref hit");
	AST_REF: assert property ($changed(vref_source) |->
		$stable(o[27:4])) else $error("chan hit");
	AST_CODE: assert property (vref_source != 2'h3)
		else $error("code");
	AST_OVR: assert property (!overrun) else $error("lost");
endmodule
bind ddsc_top ddsc_monitor u_mon (.clk, .rst, .sclk, .cs_n,
	.first_channel_code, .second_channel_code, .vref_source,
	.settle_speed, .power_down, .overrun);
`default_nettype wire

// >>> verification/ddsc_host.sv
// host serial port model
`timescale 1ns/1ps
`default_nettype none
module ddsc_host (
	input  wire logic clk,
	output var  logic sclk,
	output var  logic cs_n,
	output var  logic din
);
	initial {sclk, cs_n, din} = 3'h2;
	task automatic send(input logic [15:0] w, input int n);
		@(posedge clk);
		cs_n <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			repeat (4) @(posedge clk);
			din <= w[i];
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (10) @(posedge clk);
		cs_n <= 1'b1;
		// no stale bit once deselected
		din <= ~din;
		repeat (16) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// >>> verification/ddsc_tb_top.sv
// self-checking bench for the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module ddsc_tb_top;
	logic        clk = 1'b0, rst = 1'b1;
	logic        sclk, cs_n, din, sp, pd, ov, es, ep;
	logic [1:0]  vs, er;
	logic [11:0] fc, sc, ea, eb, eh;
	logic [15:0] w;
	logic [31:0] seed = 32'h0001441D;
	logic [15:0] hand [11] = '{16'hD002, 16'hCFFF, 16'hD000, 16'h4ABC,
		16'h9001, 16'h1555, 16'h8AAA, 16'hF003, 16'h3FFE, 16'h0123, 16'hDFFE};
	int          errors = 0, n_tests = 0;
	always #12.5 clk = ~clk;
	ddsc_top u_dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
		.din(din), .first_channel_code(fc), .second_channel_code(sc),
		.vref_source(vs), .settle_speed(sp), .power_down(pd), .overrun(ov));
	ddsc_host u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic void apply(input logic [15:0] v);
		{es, ep} = v[14:13];
		case ({v[15], v[12]})
			2'h0: {eb, eh} = {v[11:0], v[11:0]};
			2'h1: eh = v[11:0];
			2'h2: {ea, eb} = {v[11:0], eh};
			default: er = (v[1:0] == 2'h3) ? 2'h0 : v[1:0];
		endcase
	endfunction
	task automatic cmp();
		n_tests++;
		if ({fc, sc, vs, sp, pd, ov} !== {ea, eb, er, es, ep, 1'b0}) begin
			errors++;
			$display("[ERR] %0t outputs differ", $time);
		end
	endtask
	task automatic reset_dut();
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		{ea, eb, eh, er, es, ep} = 40'h0;
		// first frame no sooner than three clocks after release
		repeat (3) @(posedge clk);
		cmp();
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#1000000;
		errors++;
		$display("[ERR] %0t timeout", $time);
		test_done();
	end
	initial begin
		reset_dut();
		for (int i = 0; i < 32; i++) begin
			seed = lfsr(seed);
			w = (i < 11) ? hand[i] : (i > 30) ? 16'h005A : seed[15:0];
			u_host.send(w, (i > 30) ? 8 : 16);
			apply(w);
			cmp();
		end
		$display("test frames done");
		reset_dut();
		$display("test reset done");
		test_done();
	end
endmodule
`default_nettype wire
